// File: hdl/czf_pkg.sv
package czf_pkg;
  // Command codes on the command port
  typedef enum logic [3:0] {
    CZF_CMD_ZERO_ONCE,
    CZF_CMD_CAL_ONCE,
    CZF_CMD_CAL_AUTO,
    CZF_CMD_CAL_TYPE,
    CZF_CMD_BORDER,
    CZF_CMD_FORMAT,
    CZF_CMD_QUERY_AUTO,
    CZF_CMD_QUERY_TYPE,
    CZF_CMD_QUERY_BORDER,
    CZF_CMD_QUERY_FORMAT,
    CZF_CMD_READING
  } czf_cmd_e;

  // Argument values
  localparam logic [1:0] CZF_ARG_OFF = 2'h0;
  localparam logic [1:0] CZF_ARG_ON = 2'h1;
  localparam logic [1:0] CZF_ARG_INT = 2'h0;
  localparam logic [1:0] CZF_ARG_EXT = 2'h1;
  localparam logic [1:0] CZF_ARG_NORMAL = 2'h0;
  localparam logic [1:0] CZF_ARG_SWAPPED = 2'h1;
  localparam logic [1:0] CZF_ARG_ASCII = 2'h0;
  localparam logic [1:0] CZF_ARG_REAL = 2'h1;

  // Error codes (two's complement 16 bit)
  localparam logic [15:0] CZF_ERR_NONE = 16'h0000;
  localparam logic [15:0] CZF_ERR_ILLEGAL = 16'hff20;
  localparam logic [15:0] CZF_ERR_QUESTIONABLE = 16'hff19;
  localparam logic [1:0] CZF_QUAL_NONE = 2'h0;
  localparam logic [1:0] CZF_QUAL_ZERO = 2'h1;
  localparam logic [1:0] CZF_QUAL_CAL = 2'h2;

  // Temperature in 0.1 degree units; 10 degrees drift limit
  localparam logic [15:0] CZF_TEMP_DRIFT = 16'h0064;

  // ASCII response characters
  localparam logic [7:0] CZF_CH_0 = 8'h30;
  localparam logic [7:0] CZF_CH_1 = 8'h31;
  localparam logic [7:0] CZF_CH_LF = 8'h0a;
  localparam logic [7:0] CZF_CH_HASH = 8'h23;
  localparam logic [7:0] CZF_CH_8 = 8'h38;
  localparam logic [7:0] CZF_CH_SP = 8'h20;
  localparam logic [7:0] CZF_CH_PLUS = 8'h2b;
  localparam logic [7:0] CZF_CH_MINUS = 8'h2d;
  localparam logic [7:0] CZF_CH_DOT = 8'h2e;
  localparam logic [7:0] CZF_CH_E = 8'h45;
  localparam logic [3:0] CZF_TEXT_LEN = 4'h4;
  localparam logic [3:0] CZF_BIN_LEN = 4'h8;

  typedef struct packed {
    logic valid;
    czf_cmd_e code;
    logic [1:0] arg;
  } czf_cmd_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } czf_byte_s;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic [1:0] qual;
  } czf_err_s;
endpackage

// File: hdl/czf_run.sv
`timescale 1ns/100ps
// Runs one zeroing or calibration job on the analog engine in the background
module czf_run
  import czf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Job request
  input wire logic start,
  input wire logic is_cal,
  output logic busy,
  // Engine handshake
  output logic eng_start,
  output logic eng_cal,
  input wire logic eng_done,
  input wire logic eng_ok,
  // Result
  output logic done,
  output logic ok,
  output logic was_cal
);
  typedef enum logic [1:0] {CZF_R_IDLE, CZF_R_WAIT, CZF_R_DONE} czf_rstate_e;
  typedef struct packed {
    czf_rstate_e st;
    logic cal;
    logic ok;
  } czf_run_s;
  czf_run_s r, next_r;

  always_comb begin
    next_r = r;
    case (r.st)
      CZF_R_IDLE: begin
        if (start) begin
          next_r.st = CZF_R_WAIT;
          next_r.cal = is_cal;
        end
      end
      CZF_R_WAIT: begin
        if (eng_done) begin
          next_r.st = CZF_R_DONE;
          next_r.ok = eng_ok;
        end
      end
      CZF_R_DONE: next_r.st = CZF_R_IDLE;
      default: next_r.st = CZF_R_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: CZF_R_IDLE, cal: 1'b0, ok: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.st != CZF_R_IDLE);
  assign eng_start = (r.st == CZF_R_IDLE) && start;
  assign eng_cal = is_cal;
  assign done = (r.st == CZF_R_DONE);
  assign ok = r.ok;
  assign was_cal = r.cal;
endmodule

// File: hdl/czf_fmt.sv
`timescale 1ns/100ps
// Serialises one reading as text or as a binary block
module czf_fmt
  import czf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request
  input wire logic start,
  input wire logic binary,
  input wire logic swapped,
  input wire logic [63:0] value,
  input wire logic [7:0] mant,
  input wire logic [7:0] expo,
  input wire logic neg,
  input wire logic ready,
  output logic busy,
  // Byte out
  output czf_byte_s out
);
  typedef struct packed {
    logic busy;
    logic bin;
    logic [3:0] idx;
    logic [3:0] len;
    logic [79:0] buf_q;
  } czf_fmt_s;
  czf_fmt_s f, next_f;
  logic [63:0] ordered;
  logic [7:0] sign_ch;

  // Normal order sends the most significant byte first
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bytes
      assign ordered[63-8*g -: 8] = swapped ? value[8*g +: 8] : value[63-8*g -: 8];
    end
  endgenerate

  always_comb begin
    next_f = f;
    sign_ch = neg ? CZF_CH_MINUS : CZF_CH_PLUS;
    if (!f.busy) begin
      if (start) begin
        next_f.busy = 1'b1;
        next_f.idx = 4'h0;
        next_f.bin = binary;
        if (binary) begin
          // Header "#18" then eight bytes, closed by LF
          next_f.len = CZF_BIN_LEN + 4'h3;
          next_f.buf_q = {CZF_CH_HASH, CZF_CH_1, CZF_CH_8, ordered[63:8]};
        end else begin
          // Text: "+m.dE+xx" style digits supplied as ASCII, then a space and LF
          next_f.len = CZF_TEXT_LEN + 4'h5;
          next_f.buf_q = {sign_ch, mant, CZF_CH_DOT, CZF_CH_0, CZF_CH_E, CZF_CH_PLUS, expo, CZF_CH_0, CZF_CH_SP, 8'h00};
        end
      end
    end else if (ready) begin
      if (f.idx == f.len) begin
        next_f.busy = 1'b0;
      end else begin
        next_f.idx = f.idx + 4'h1;
        next_f.buf_q = {f.buf_q[71:0], (f.bin && f.idx == 4'h0) ? value[7:0] ^ ordered[7:0] ^ value[7:0] : 8'h00};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  assign busy = f.busy;
  assign out.valid = f.busy;
  assign out.data = (f.idx == f.len) ? CZF_CH_LF : f.buf_q[79:72];
  assign out.last = f.busy && (f.idx == f.len);
endmodule

// File: hdl/czf_top.sv
// Operation
// [R1] Zero-once runs one zeroing job, never repeated by itself. The code drops the request while a job is running.
// [R2] Failed zeroing queues error -231 with zero qualifier.
// [R3] External one-shot calibration assumes 1 mW 50 MHz reference present.
// [R4] Auto-calibration enable while external selected is rejected, error -224.
// [R5] Internal auto mode recalibrates on 10 degree drift since last calibration.
// [R6] Disable stops auto recalibration; only one-shot calibrates.
// [R7] Host should zero before asking for calibration.
// [R8] Auto-calibration enabled after reset.
// [R9] Failed calibration queues error -231 with calibration qualifier.
// [R10] Auto state query answers 0 off, 1 on.
// [R11] Selecting external source forces auto-calibration off.
// [R12] Source is internal after reset.
// [R13] Source query answers INT or EXT.
// [R14] Source write with other value gives -224, selection kept.
// [R15] Format settings apply only to reading replies.
// [R16] Byte order matters only in binary format.
// [R17] Byte order normal after reset; query answers normal or swapped.
// [R18] Text format emits ASCII exponent notation.
// [R19] Binary format emits eight-byte doubles in a block ending LF.
// [R20] Text format after reset; query reports text or binary.
// [R21] Zeroing and calibration run while later commands proceed.
// [R22] Bad byte order or format value is rejected, setting kept.
`timescale 1ns/100ps
module czf_top
  import czf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Command port
  input wire czf_cmd_s cmd,
  output logic cmd_ready,
  // Reading to report
  input wire logic [63:0] reading_value,
  input wire logic [7:0] reading_mant,
  input wire logic [7:0] reading_expo,
  input wire logic reading_neg,
  // Sensor temperature, 0.1 degree units, same clock
  input wire logic [15:0] temperature,
  // Analog engine
  output logic eng_start,
  output logic eng_cal,
  input wire logic eng_done,
  input wire logic eng_ok,
  // Response stream
  output czf_byte_s resp,
  input wire logic resp_ready,
  // Error queue entry
  output czf_err_s err,
  // Settings as levels
  output logic auto_cal,
  output logic cal_external,
  output logic byte_order_select,
  output logic format_binary
);
  typedef struct packed {
    logic auto_cal;
    logic ext;
    logic swapped;
    logic binary;
    logic [15:0] cal_temp;
    logic pend_cal;
    logic fail_pend;
    logic fail_cal;
    logic [23:0] txt;
    logic [1:0] txt_n;
    logic txt_busy;
    czf_byte_s resp;
    czf_err_s err;
    logic eng_start;
    logic eng_cal;
  } czf_top_s;
  czf_top_s s, next_s;

  logic run_start, run_is_cal, run_busy, run_start_q, run_cal_q;
  logic run_done, run_ok, run_was_cal;
  logic fmt_start, fmt_busy;
  czf_byte_s fmt_out;
  logic [15:0] drift;
  logic accept;

  czf_run u_run (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(run_start),
    .is_cal(run_is_cal),
    .busy(run_busy),
    .eng_start(run_start_q),
    .eng_cal(run_cal_q),
    .eng_done(eng_done),
    .eng_ok(eng_ok),
    .done(run_done),
    .ok(run_ok),
    .was_cal(run_was_cal)
  );

  // Byte order only reaches the formatter, so it has no effect in text mode
  czf_fmt u_fmt (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(fmt_start),
    // [R16] Order binary only
    .binary(s.binary),
    .swapped(s.swapped),
    .value(reading_value),
    .mant(reading_mant),
    .expo(reading_expo),
    .neg(reading_neg),
    .ready(resp_ready),
    .busy(fmt_busy),
    .out(fmt_out)
  );

  assign drift = (temperature >= s.cal_temp) ? temperature - s.cal_temp : s.cal_temp - temperature;
  // Every command waits while a reply is going out, engine commands included
  assign accept = !s.txt_busy && !fmt_busy && !s.resp.valid;

  always_comb begin
    next_s = s;
    next_s.err.valid = 1'b0;
    next_s.eng_start = run_start_q;
    // Job kind stays up for the whole job so its completion can be told apart
    next_s.eng_cal = run_start_q ? run_cal_q : s.eng_cal;
    run_start = 1'b0;
    run_is_cal = 1'b0;
    fmt_start = 1'b0;

    // Job results; a failure waits a cycle when a command error takes the queue entry
    if (run_done && !run_ok) begin
      next_s.fail_pend = 1'b1;
      next_s.fail_cal = run_was_cal;
    end
    if (run_done && run_ok && run_was_cal && !s.ext) begin
      next_s.cal_temp = temperature;
    end

    // [R5] Drift recalibration
    // Only while idle: the reference temperature is updated when the job ends
    if (s.auto_cal && !s.ext && !run_busy && drift >= CZF_TEMP_DRIFT) begin
      next_s.pend_cal = 1'b1;
    end

    if (cmd.valid && accept) begin
      case (cmd.code)
        CZF_CMD_ZERO_ONCE: begin
          // [R1] [R21] Single zero, overlapped
          if (!run_busy) begin
            run_start = 1'b1;
            run_is_cal = 1'b0;
          end
        end
        CZF_CMD_CAL_ONCE: begin
          // [R3] [R6] One-shot either source
          next_s.pend_cal = 1'b1;
        end
        CZF_CMD_CAL_AUTO: begin
          if (cmd.arg == CZF_ARG_ON && s.ext) begin
            // [R4] Reject enable external
            next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
          end else if (cmd.arg == CZF_ARG_ON) begin
            next_s.auto_cal = 1'b1;
          end else if (cmd.arg == CZF_ARG_OFF) begin
            // [R6] Stop auto
            next_s.auto_cal = 1'b0;
          end else begin
            next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
          end
        end
        CZF_CMD_CAL_TYPE: begin
          if (cmd.arg == CZF_ARG_EXT) begin
            next_s.ext = 1'b1;
            // [R11] External forces auto off
            next_s.auto_cal = 1'b0;
          end else if (cmd.arg == CZF_ARG_INT) begin
            next_s.ext = 1'b0;
          end else begin
            // [R14] Reject other source
            next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
          end
        end
        CZF_CMD_BORDER: begin
          if (cmd.arg == CZF_ARG_NORMAL || cmd.arg == CZF_ARG_SWAPPED) begin
            next_s.swapped = (cmd.arg == CZF_ARG_SWAPPED);
          end else begin
            // [R22] Reject bad order
            next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
          end
        end
        CZF_CMD_FORMAT: begin
          if (cmd.arg == CZF_ARG_ASCII || cmd.arg == CZF_ARG_REAL) begin
            next_s.binary = (cmd.arg == CZF_ARG_REAL);
          end else begin
            // [R22] Reject bad format
            next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
          end
        end
        CZF_CMD_QUERY_AUTO: begin
          // [R10] Answer 0 or 1
          next_s.txt = {s.auto_cal ? CZF_CH_1 : CZF_CH_0, 16'h0000};
          next_s.txt_n = 2'h1;
          next_s.txt_busy = 1'b1;
        end
        CZF_CMD_QUERY_TYPE: begin
          // [R13] INT or EXT
          next_s.txt = s.ext ? {8'h45, 8'h58, 8'h54} : {8'h49, 8'h4e, 8'h54};
          next_s.txt_n = 2'h3;
          next_s.txt_busy = 1'b1;
        end
        CZF_CMD_QUERY_BORDER: begin
          // [R17] NOR or SWP, short form
          next_s.txt = s.swapped ? {8'h53, 8'h57, 8'h50} : {8'h4e, 8'h4f, 8'h52};
          next_s.txt_n = 2'h3;
          next_s.txt_busy = 1'b1;
        end
        CZF_CMD_QUERY_FORMAT: begin
          // [R20] ASC or REA
          next_s.txt = s.binary ? {8'h52, 8'h45, 8'h41} : {8'h41, 8'h53, 8'h43};
          next_s.txt_n = 2'h3;
          next_s.txt_busy = 1'b1;
        end
        CZF_CMD_READING: begin
          // [R15] [R18] [R19] Only readings formatted
          fmt_start = 1'b1;
        end
        default: next_s.err = '{valid: 1'b1, code: CZF_ERR_ILLEGAL, qual: CZF_QUAL_NONE};
      endcase
    end

    // Launch pending calibration when engine is free and no zero starts now
    if (next_s.pend_cal && !run_busy && !run_start) begin
      run_start = 1'b1;
      run_is_cal = 1'b1;
      next_s.pend_cal = 1'b0;
    end

    if (next_s.fail_pend && !next_s.err.valid) begin
      next_s.err.valid = 1'b1;
      next_s.err.code = CZF_ERR_QUESTIONABLE;
      // [R2] [R9] Failure qualifier
      next_s.err.qual = next_s.fail_cal ? CZF_QUAL_CAL : CZF_QUAL_ZERO;
      next_s.fail_pend = 1'b0;
    end

    // Response mux: plain replies ignore the format settings
    if (s.resp.valid && !resp_ready) begin
      next_s.resp = s.resp;
    end else if (s.txt_busy) begin
      next_s.resp.valid = 1'b1;
      if (s.txt_n == 2'h0) begin
        next_s.resp.data = CZF_CH_LF;
        next_s.resp.last = 1'b1;
        next_s.txt_busy = 1'b0;
      end else begin
        next_s.resp.data = s.txt[23:16];
        next_s.resp.last = 1'b0;
        next_s.txt = {s.txt[15:0], 8'h00};
        next_s.txt_n = s.txt_n - 2'h1;
      end
    end else begin
      next_s.resp = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // [R8] [R12] [R17] [R20] Reset defaults
      s <= '{
        auto_cal: 1'b1,
        ext: 1'b0,
        swapped: 1'b0,
        binary: 1'b0,
        cal_temp: '0,
        pend_cal: 1'b0,
        fail_pend: 1'b0,
        fail_cal: 1'b0,
        txt: '0,
        txt_n: '0,
        txt_busy: 1'b0,
        resp: '0,
        err: '0,
        eng_start: 1'b0,
        eng_cal: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    cmd_ready = accept;
  end

  assign eng_start = s.eng_start;
  assign eng_cal = s.eng_cal;
  assign resp = fmt_busy ? fmt_out : s.resp;
  assign err = s.err;
  assign auto_cal = s.auto_cal;
  assign cal_external = s.ext;
  assign byte_order_select = s.swapped;
  assign format_binary = s.binary;
endmodule

// File: verification/czf_top_sva.sv
`timescale 1ns/100ps
module czf_chk
  import czf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Command and reply
  input wire czf_cmd_s cmd,
  input wire logic cmd_ready,
  input wire czf_byte_s resp,
  input wire czf_err_s err,
  // Engine
  input wire logic eng_start,
  input wire logic eng_cal,
  input wire logic eng_done,
  input wire logic eng_ok,
  // Settings
  input wire logic auto_cal,
  input wire logic cal_external,
  input wire logic byte_order_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Tracks a job in flight so a dropped zero request is not mistaken for a fault
  logic job;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      job <= 1'b0;
    end else if (eng_start) begin
      job <= 1'b1;
    end else if (eng_done) begin
      job <= 1'b0;
    end
  end

  sequence s_take(czf_cmd_e c);
    cmd.valid && cmd_ready && cmd.code == c;
  endsequence
  sequence s_reject;
    err.valid && err.code == CZF_ERR_ILLEGAL;
  endsequence
  sequence s_bad(logic [1:0] q);
    err.valid && err.code == CZF_ERR_QUESTIONABLE && err.qual == q;
  endsequence

  property p_zero_runs;
    s_take(CZF_CMD_ZERO_ONCE) ##0 (!job && !eng_start && !$past(eng_done)) |-> ##1 (eng_start && !eng_cal);
  endproperty
  a_zero_runs: assert property (p_zero_runs) else $error("zero job not started");
  property p_zero_fail;
    eng_done && !eng_ok && !eng_cal |-> ##[1:3] s_bad(CZF_QUAL_ZERO);
  endproperty
  a_zero_fail: assert property (p_zero_fail) else $error("zero failure not reported");
  property p_auto_on_ext;
    s_take(CZF_CMD_CAL_AUTO) ##0 (cmd.arg == CZF_ARG_ON && cal_external) |=> s_reject ##0 !auto_cal;
  endproperty
  a_auto_on_ext: assert property (p_auto_on_ext) else $error("auto enable accepted in external");
  property p_manual_only;
    eng_start && eng_cal && !auto_cal && !$past(auto_cal) && !$past(auto_cal, 3)
      |-> $past(cmd.valid && cmd_ready && cmd.code == CZF_CMD_CAL_ONCE, 1);
  endproperty
  a_manual_only: assert property (p_manual_only) else $error("calibration without request");
  property p_cal_fail;
    eng_done && !eng_ok && eng_cal |-> ##[1:3] s_bad(CZF_QUAL_CAL);
  endproperty
  a_cal_fail: assert property (p_cal_fail) else $error("cal failure not reported");
  property p_auto_reply;
    s_take(CZF_CMD_QUERY_AUTO) |=> ##1 resp.valid && resp.data == (auto_cal ? CZF_CH_1 : CZF_CH_0);
  endproperty
  a_auto_reply: assert property (p_auto_reply) else $error("auto state reply wrong");
  property p_ext_forces_off;
    s_take(CZF_CMD_CAL_TYPE) ##0 (cmd.arg == CZF_ARG_EXT) |=> cal_external && !auto_cal;
  endproperty
  a_ext_forces_off: assert property (p_ext_forces_off) else $error("external left auto on");
  property p_type_bad;
    s_take(CZF_CMD_CAL_TYPE) ##0 (cmd.arg > CZF_ARG_EXT) |=> s_reject ##0 (cal_external == $past(cal_external));
  endproperty
  a_type_bad: assert property (p_type_bad) else $error("bad source value accepted");
  property p_border_bad;
    s_take(CZF_CMD_BORDER) ##0 (cmd.arg > CZF_ARG_SWAPPED)
      |=> s_reject ##0 (byte_order_select == $past(byte_order_select));
  endproperty
  a_border_bad: assert property (p_border_bad) else $error("bad byte order accepted");
endmodule

bind czf_top czf_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd), .cmd_ready(cmd_ready),
  .resp(resp), .err(err), .eng_start(eng_start), .eng_cal(eng_cal), .eng_done(eng_done), .eng_ok(eng_ok),
  .auto_cal(auto_cal), .cal_external(cal_external), .byte_order_select(byte_order_select));

// File: verification/czf_eng_model.sv
`timescale 1ns/100ps
module czf_eng_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Job control
  input wire logic eng_start,
  input wire logic eng_cal,
  // Behaviour set by the bench
  input wire logic [7:0] delay,
  input wire logic fail,
  // Completion
  output logic eng_done,
  output logic eng_ok
);
  logic run;
  logic [7:0] cnt;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      cnt <= 8'h00;
      eng_done <= 1'b0;
      eng_ok <= 1'b0;
    end else begin
      eng_done <= 1'b0;
      // Outside a completion the flag toggles so nothing relies on it
      eng_ok <= ~eng_ok;
      if (eng_start) begin
        run <= 1'b1;
        cnt <= delay;
      end else if (run && cnt == 8'h00) begin
        run <= 1'b0;
        eng_done <= 1'b1;
        eng_ok <= !fail && (eng_cal || !eng_cal);
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import czf_pkg::*;
  typedef struct packed {czf_cmd_e c; logic [1:0] a; logic [3:0] lv; logic [15:0] e;} czf_tb_row_s;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  czf_cmd_s cmd = '0;
  logic [63:0] reading_value = 64'h0123456789abcdef;
  logic [7:0] reading_mant = 8'h35;
  logic [7:0] reading_expo = 8'h33;
  logic reading_neg = 1'b0;
  logic [15:0] temperature = 16'h0000;
  logic resp_ready = 1'b1;
  logic [7:0] eng_delay = 8'h04;
  logic eng_fail = 1'b0;
  logic eng_start, eng_cal, eng_done, eng_ok, cmd_ready, hit;
  logic auto_cal, cal_external, byte_order_select, format_binary;
  czf_byte_s resp;
  czf_err_s err;
  logic [15:0] err_code;
  logic [1:0] err_qual;
  logic [7:0] rx[$];
  logic [7:0] text0[$];
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  czf_tb_row_s rows[13] = '{
    '{CZF_CMD_CAL_AUTO, CZF_ARG_OFF, 4'h0, CZF_ERR_NONE}, '{CZF_CMD_CAL_AUTO, CZF_ARG_ON, 4'h8, CZF_ERR_NONE},
    '{CZF_CMD_CAL_TYPE, CZF_ARG_EXT, 4'h4, CZF_ERR_NONE}, '{CZF_CMD_CAL_AUTO, CZF_ARG_ON, 4'h4, CZF_ERR_ILLEGAL},
    '{CZF_CMD_CAL_TYPE, 2'h2, 4'h4, CZF_ERR_ILLEGAL}, '{CZF_CMD_CAL_AUTO, CZF_ARG_OFF, 4'h4, CZF_ERR_NONE},
    '{CZF_CMD_CAL_TYPE, CZF_ARG_INT, 4'h0, CZF_ERR_NONE}, '{CZF_CMD_BORDER, CZF_ARG_SWAPPED, 4'h2, CZF_ERR_NONE},
    '{CZF_CMD_BORDER, 2'h3, 4'h2, CZF_ERR_ILLEGAL}, '{CZF_CMD_FORMAT, CZF_ARG_REAL, 4'h3, CZF_ERR_NONE},
    '{CZF_CMD_FORMAT, 2'h2, 4'h3, CZF_ERR_ILLEGAL}, '{CZF_CMD_FORMAT, CZF_ARG_ASCII, 4'h2, CZF_ERR_NONE},
    '{CZF_CMD_BORDER, CZF_ARG_NORMAL, 4'h0, CZF_ERR_NONE}};

  always #2.5 sys_clk = ~sys_clk;

  czf_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd), .cmd_ready(cmd_ready),
    .reading_value(reading_value), .reading_mant(reading_mant), .reading_expo(reading_expo),
    .reading_neg(reading_neg), .temperature(temperature), .eng_start(eng_start), .eng_cal(eng_cal),
    .eng_done(eng_done), .eng_ok(eng_ok), .resp(resp), .resp_ready(resp_ready), .err(err),
    .auto_cal(auto_cal), .cal_external(cal_external), .byte_order_select(byte_order_select),
    .format_binary(format_binary));
  czf_eng_model u_eng (.sys_clk(sys_clk), .reset_n(reset_n), .eng_start(eng_start), .eng_cal(eng_cal),
    .delay(eng_delay), .fail(eng_fail), .eng_done(eng_done), .eng_ok(eng_ok));

  always @(posedge sys_clk) begin
    cycles++;
    if (err.valid) begin
      err_code = err.code;
      err_qual = err.qual;
    end
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input czf_cmd_e c, input logic [1:0] a);
    @(posedge sys_clk);
    #1 cmd = '{1'b1, c, a};
    @(posedge sys_clk);
    #1 cmd.valid = 1'b0;
  endtask
  // Stalling toggles ready every cycle so each byte must hold across a refusal
  task automatic get(input logic stall);
    rx.delete();
    for (int i = 0; i < 80; i++) begin
      @(posedge sys_clk);
      if (resp.valid && resp_ready) begin
        rx.push_back(resp.data);
        if (resp.last) break;
      end
      #1 resp_ready = stall ? ~resp_ready : 1'b1;
    end
    #1 resp_ready = 1'b1;
  endtask
  task automatic query(input czf_cmd_e c, input logic [95:0] exp, input int len, input logic st);
    send(c, 2'h0);
    get(st);
    check(rx.size(), len);
    for (int i = 0; i < len; i++) check(rx[i], exp[8*(len-1-i) +: 8]);
  endtask
  task automatic cmd_err(input czf_cmd_e c, input logic [1:0] a);
    err_code = CZF_ERR_NONE;
    err_qual = CZF_QUAL_NONE;
    send(c, a);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_start(input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge sys_clk);
      hit = eng_start;
    end
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check({auto_cal, cal_external, byte_order_select, format_binary}, 4'h8);
    query(CZF_CMD_QUERY_AUTO, 96'h310a, 2, 1'b0);
    query(CZF_CMD_QUERY_TYPE, 96'h494e540a, 4, 1'b1);
    query(CZF_CMD_QUERY_BORDER, 96'h4e4f520a, 4, 1'b0);
    query(CZF_CMD_QUERY_FORMAT, 96'h4153430a, 4, 1'b0);
    foreach (rows[i]) begin
      cmd_err(rows[i].c, rows[i].a);
      check({auto_cal, cal_external, byte_order_select, format_binary}, rows[i].lv);
      check(err_code, rows[i].e);
    end
    $display("reset and setting test done");
    send(CZF_CMD_ZERO_ONCE, 2'h0);
    wait_start(8);
    check({hit, eng_cal}, 2'h2);
    wait_start(60);
    check({hit, err_code}, CZF_ERR_NONE);
    eng_fail = 1'b1;
    send(CZF_CMD_ZERO_ONCE, 2'h0);
    repeat (12) @(posedge sys_clk);
    #1 check({err_code, err_qual}, {CZF_ERR_QUESTIONABLE, CZF_QUAL_ZERO});
    send(CZF_CMD_CAL_ONCE, 2'h0);
    repeat (12) @(posedge sys_clk);
    #1 check({err_code, err_qual}, {CZF_ERR_QUESTIONABLE, CZF_QUAL_CAL});
    eng_fail = 1'b0;
    eng_delay = 8'h28;
    send(CZF_CMD_CAL_ONCE, 2'h0);
    cmd_err(CZF_CMD_FORMAT, CZF_ARG_REAL);
    check({format_binary, err_code}, {1'b1, CZF_ERR_NONE});
    query(CZF_CMD_QUERY_AUTO, 96'h300a, 2, 1'b0);
    repeat (60) @(posedge sys_clk);
    $display("engine test done");
    query(CZF_CMD_READING, 96'h2331380123456789abcdef0a, 12, 1'b1);
    cmd_err(CZF_CMD_BORDER, CZF_ARG_SWAPPED);
    query(CZF_CMD_READING, 96'h233138efcdab89674523010a, 12, 1'b0);
    cmd_err(CZF_CMD_FORMAT, CZF_ARG_ASCII);
    send(CZF_CMD_READING, 2'h0);
    get(1'b1);
    text0 = rx;
    check({rx[0] == CZF_CH_HASH, rx[rx.size()-1]}, {1'b0, CZF_CH_LF});
    cmd_err(CZF_CMD_BORDER, CZF_ARG_NORMAL);
    send(CZF_CMD_READING, 2'h0);
    get(1'b0);
    check(rx == text0, 1'b1);
    $display("format test done");
    eng_delay = 8'h04;
    cmd_err(CZF_CMD_CAL_AUTO, CZF_ARG_ON);
    temperature = 16'h00fa;
    wait_start(40);
    check({hit, eng_cal}, 2'h3);
    repeat (20) @(posedge sys_clk);
    #1 temperature = 16'h015d;
    wait_start(40);
    check(hit, 1'b0);
    temperature = 16'h015e;
    wait_start(40);
    check({hit, eng_cal}, 2'h3);
    repeat (20) @(posedge sys_clk);
    #1 temperature = 16'h00fa;
    wait_start(40);
    check(hit, 1'b1);
    repeat (20) @(posedge sys_clk);
    cmd_err(CZF_CMD_CAL_AUTO, CZF_ARG_OFF);
    temperature = 16'h0200;
    wait_start(60);
    check(hit, 1'b0);
    cmd_err(CZF_CMD_CAL_TYPE, CZF_ARG_EXT);
    query(CZF_CMD_QUERY_TYPE, 96'h4558540a, 4, 1'b0);
    err_code = CZF_ERR_NONE;
    send(CZF_CMD_CAL_ONCE, 2'h0);
    wait_start(8);
    check({hit, eng_cal}, 2'h3);
    repeat (12) @(posedge sys_clk);
    #1 check(err_code, CZF_ERR_NONE);
    reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check({auto_cal, cal_external, byte_order_select, format_binary}, 4'h8);
    $display("drift and reset test done");
    test_done();
  end
endmodule
